// *** rtl/tmh_regs.svh ***
// Constants for the timer half: mode codes, reset values and field positions
// Operation
// - Split 16-bit operation is entered when the global configuration holds 0x4.
// - One-shot and periodic modes count down 16 bits with 8-bit prescaler.
// - Half-mode 0x1 selects one-shot, 0x2 selects periodic.
// - Enabled counter counts down, reloads load and prescale after reaching zero.
// - One-shot clears its own enable after reload; periodic keeps counting.
// - Reaching zero sets raw time-out flag, held until software clears it.
// - Unmasked time-out also sets masked flag and raises the interrupt.
// - Time-out trigger pulse only when output trigger enable is set.
// - Interval load write while running is taken on the next clock.
// - With debug stall set, counting freezes while the processor is halted.
// - Each count step takes prescale plus one system clocks.
// - Edge count, edge time and PWM modes step without the prescaler.
// - Capture-mode 0 edge count uses rising, falling or both edges.
// - Each edge decrements by one; count equal match sets match flags.
// - After match, reload from load register, clear enable, ignore edges.
// - Capture-mode 1 edge time runs free down-counter from load value.
// - Each edge copies count to timer value and sets capture flags.
// - Edge time keeps counting after capture, reloads at zero.
// - PWM mode needs alternate select 1, capture-mode 0, half-mode 0x2.
// - PWM counts down, reloads after zero, runs, asserts no flags.
// - PWM output sets at load value, clears at match, optional invert.
// - Half-mode 0x3 gives edge count with capture 0, edge time with 1.
// - Reset sets counter and load to 0xFFFF, prescale to 0x00.
`ifndef TMH_REGS_SVH
`define TMH_REGS_SVH

`define TMH_CFG_SPLIT      3'h4
`define TMH_MR_ONESHOT     2'h1
`define TMH_MR_PERIODIC    2'h2
`define TMH_MR_CAPTURE     2'h3
`define TMH_LOAD_RESET     16'hffff
`define TMH_PRESCALE_RESET 8'h00
`define TMH_COUNT_ZERO     16'h0000
`define TMH_EVT_RISE       2'h0
`define TMH_EVT_FALL       2'h1
`define TMH_EVT_BOTH       2'h3
`define TMH_FLAG_TIMEOUT   0
`define TMH_FLAG_MATCH     1
`define TMH_FLAG_CAPTURE   2
`define TMH_EDGE_HOLD_CLKS 2

`endif

// *** rtl/tmh_pkg.sv ***
// Types shared by the timer half modules
package tmh_pkg;
  typedef enum logic [2:0] {
    TMH_IDLE     = 3'b000,
    TMH_ONESHOT  = 3'b001,
    TMH_PERIODIC = 3'b010,
    TMH_EDGE_CNT = 3'b011,
    TMH_EDGE_TIM = 3'b100,
    TMH_PWM      = 3'b101
  } tmh_mode_t;

  typedef struct packed {
    logic        enable;
    logic [15:0] count;
    logic [15:0] load;
    logic [7:0]  prescale;
    logic [15:0] value;
    logic [2:0]  raw;
    logic        pwm_level;
    logic        trigger;
  } tmh_state_t;
endpackage

// *** rtl/tmh_link_if.sv ***
// Signals passed between the timer core and its helper modules
interface tmh_link_if;
  logic       edge_event;
  logic       tick;
  logic       run;
  logic       restart;
  logic [7:0] prescale;

  modport edge_src (output edge_event);
  modport tick_src (input run, input restart, input prescale, output tick);
  modport core     (input edge_event, input tick,
                    output run, output restart, output prescale);
endinterface

// *** rtl/tmh_edge_det.sv ***
// Capture pin synchroniser and selected edge detector
`include "tmh_regs.svh"
module tmh_edge_det (
  // Clock and reset
  input  wire logic       core_clk_in,
  input  wire logic       reset_n_in,
  // Pin and edge selection
  input  wire logic       ccp_pin_in,
  input  wire logic [1:0] event_sel_in,
  // Edge pulse to the core
  tmh_link_if.edge_src    link
);
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
  } tmh_edge_state_t;

  tmh_edge_state_t st;
  tmh_edge_state_t next_st;
  logic            rise;
  logic            fall;

  // Two flops synchronise, the third remembers the last level
  always_comb begin
    next_st       = st;
    next_st.sync1 = ccp_pin_in;
    next_st.sync2 = st.sync1;
    next_st.prev  = st.sync2;
  end

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Edges are seen only past the synchroniser
  assign rise = st.sync2 & ~st.prev;
  assign fall = ~st.sync2 & st.prev;
  always_comb begin
    case (event_sel_in)
      `TMH_EVT_RISE: link.edge_event = rise;
      `TMH_EVT_FALL: link.edge_event = fall;
      `TMH_EVT_BOTH: link.edge_event = rise | fall;
      default:       link.edge_event = 1'b0;
    endcase
  end

  a_edge_single: assert property (
    @(posedge core_clk_in) disable iff (!reset_n_in)
    link.edge_event |-> (rise || fall) && event_sel_in != 2'h2)
    else $error("edge reported without a selected pin edge");
endmodule

// *** rtl/tmh_prescaler.sv ***
// Prescaler giving one count step every prescale plus one clocks
module tmh_prescaler (
  // Clock and reset
  input  wire logic core_clk_in,
  input  wire logic reset_n_in,
  // Step control from the core
  tmh_link_if.tick_src link
);
  typedef struct packed {
    logic [7:0] pcount;
  } tmh_pre_state_t;

  tmh_pre_state_t st;
  tmh_pre_state_t next_st;

  // Step when the countdown is spent; restart reloads the divider
  assign link.tick = link.run & (st.pcount == 8'h00);

  always_comb begin
    next_st = st;
    if (link.restart || link.tick) begin
      next_st.pcount = link.prescale;
    end else if (link.run) begin
      next_st.pcount = st.pcount - 8'h01;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // With no prescale a step is followed at once by the next one
  sequence s_tick_gap;
    link.tick && link.prescale == 8'h00 && !link.restart ##1 link.run;
  endsequence

  a_tick_spacing: assert property (
    @(posedge core_clk_in) disable iff (!reset_n_in)
    link.tick && link.prescale != 8'h00 |=> !link.tick)
    else $error("prescaler stepped on two cycles in a row");

  a_tick_period: assert property (
    @(posedge core_clk_in) disable iff (!reset_n_in)
    s_tick_gap |-> link.tick)
    else $error("prescaler did not step every clock");
endmodule

// *** rtl/tmh_half.sv ***
// One 16-bit timer half: one-shot, periodic, edge count, edge time, PWM
`include "tmh_regs.svh"
module tmh_half (
  // Clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        reset_n_in,
  // Configuration
  input  wire logic [2:0]  global_config_in,
  input  wire logic [1:0]  half_mode_in,
  input  wire logic        capture_mode_in,
  input  wire logic        alt_mode_select_in,
  input  wire logic [1:0]  event_sel_in,
  input  wire logic        trigger_enable_in,
  input  wire logic        stall_enable_in,
  input  wire logic        output_invert_in,
  input  wire logic [15:0] match_in,
  input  wire logic [2:0]  int_mask_in,
  // Software writes
  input  wire logic        enable_wr_in,
  input  wire logic        enable_data_in,
  input  wire logic        load_wr_in,
  input  wire logic [15:0] load_data_in,
  input  wire logic        prescale_wr_in,
  input  wire logic [7:0]  prescale_data_in,
  input  wire logic [2:0]  int_clear_in,
  // Debug
  input  wire logic        debug_halt_in,
  // Capture/compare pin
  input  wire logic        ccp_pin_in,
  output logic             ccp_pin_out,
  output logic             ccp_oe_n_out,
  // Status
  output logic             enable_out,
  output logic [15:0]      timer_value_out,
  output logic [15:0]      load_out,
  output logic [7:0]       prescale_out,
  output logic [2:0]       raw_status_out,
  output logic [2:0]       masked_status_out,
  output logic             irq_out,
  output logic             adc_trigger_out
);
  tmh_pkg::tmh_state_t st;
  tmh_pkg::tmh_state_t next_st;
  tmh_pkg::tmh_mode_t  mode;
  tmh_link_if          link ();

  logic        freeze;
  logic        active;
  logic        at_zero;
  logic        timeout;
  logic        match_hit;
  logic [15:0] count_dec;
  logic [2:0]  flag_set;

  // Work out the operating mode from the configuration bits
  function automatic tmh_pkg::tmh_mode_t decode_mode(
    input logic [2:0] cfg,
    input logic [1:0] mr,
    input logic       cmr,
    input logic       ams
  );
    tmh_pkg::tmh_mode_t m;
    m = tmh_pkg::TMH_IDLE;
    if (cfg == `TMH_CFG_SPLIT) begin
      if (ams && !cmr && mr == `TMH_MR_PERIODIC) begin
        m = tmh_pkg::TMH_PWM;
      end else if (mr == `TMH_MR_CAPTURE) begin
        m = cmr ? tmh_pkg::TMH_EDGE_TIM : tmh_pkg::TMH_EDGE_CNT;
      end else if (mr == `TMH_MR_ONESHOT) begin
        m = tmh_pkg::TMH_ONESHOT;
      end else if (mr == `TMH_MR_PERIODIC) begin
        m = tmh_pkg::TMH_PERIODIC;
      end
    end
    return m;
  endfunction

  assign mode      = decode_mode(global_config_in, half_mode_in,
                                 capture_mode_in, alt_mode_select_in);
  assign freeze    = stall_enable_in & debug_halt_in;
  assign active    = st.enable & (mode != tmh_pkg::TMH_IDLE) & ~freeze;
  assign at_zero   = (st.count == `TMH_COUNT_ZERO);
  assign count_dec = st.count - 16'h0001;

  // Helper modules: pin edges and the prescaler step
  tmh_edge_det u_edge (
    .core_clk_in  (core_clk_in),
    .reset_n_in   (reset_n_in),
    .ccp_pin_in   (ccp_pin_in),
    .event_sel_in (event_sel_in),
    .link         (link.edge_src)
  );

  tmh_prescaler u_pre (
    .core_clk_in (core_clk_in),
    .reset_n_in  (reset_n_in),
    .link        (link.tick_src)
  );

  // Only the timer modes use the prescaler
  assign link.run      = active & ((mode == tmh_pkg::TMH_ONESHOT) |
                                   (mode == tmh_pkg::TMH_PERIODIC));
  assign link.restart  = ~st.enable | load_wr_in | prescale_wr_in;
  assign link.prescale = st.prescale;

  // Events of the current cycle
  assign timeout   = link.tick & at_zero;
  assign match_hit = active & (mode == tmh_pkg::TMH_EDGE_CNT) &
                     link.edge_event & (count_dec == match_in);

  // Next-state logic for every mode
  always_comb begin
    next_st         = st;
    next_st.trigger = 1'b0;
    flag_set        = 3'h0;
    case (mode)
      tmh_pkg::TMH_ONESHOT,
      tmh_pkg::TMH_PERIODIC: begin
        if (link.tick) begin
          if (at_zero) begin
            next_st.count = st.load;
            flag_set[`TMH_FLAG_TIMEOUT] = 1'b1;
            next_st.trigger = trigger_enable_in;
            if (mode == tmh_pkg::TMH_ONESHOT) begin
              next_st.enable = 1'b0;
            end
          end else begin
            next_st.count = count_dec;
          end
        end
        next_st.value = next_st.count;
      end
      tmh_pkg::TMH_EDGE_CNT: begin
        if (active && link.edge_event) begin
          if (match_hit) begin
            next_st.count = st.load;
            next_st.enable = 1'b0;
            flag_set[`TMH_FLAG_MATCH] = 1'b1;
          end else begin
            next_st.count = count_dec;
          end
        end
        next_st.value = next_st.count;
      end
      tmh_pkg::TMH_EDGE_TIM: begin
        if (active) begin
          next_st.count = at_zero ? st.load : count_dec;
          if (link.edge_event) begin
            next_st.value = st.count;
            flag_set[`TMH_FLAG_CAPTURE] = 1'b1;
          end
        end
      end
      tmh_pkg::TMH_PWM: begin
        if (active) begin
          next_st.count = at_zero ? st.load : count_dec;
          if (next_st.count == st.load) begin
            next_st.pwm_level = 1'b1;
          end else if (next_st.count == match_in) begin
            next_st.pwm_level = 1'b0;
          end
        end
        next_st.value = next_st.count;
      end
      default: begin
        next_st.value = st.count;
      end
    endcase
    // Software clears flags, but a new event in the same cycle wins
    next_st.raw = (st.raw & ~int_clear_in) | flag_set;
    if (prescale_wr_in) begin
      next_st.prescale = prescale_data_in;
    end
    if (load_wr_in) begin
      next_st.load  = load_data_in;
      next_st.count = load_data_in;
    end
    if (enable_wr_in) begin
      next_st.enable = enable_data_in;
    end
    // Value follows the count, load writes included, except in edge time
    if (mode != tmh_pkg::TMH_EDGE_TIM) begin
      next_st.value = next_st.count;
    end
  end

  // State register, reset to documented values
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      st.enable    <= 1'b0;
      st.count     <= `TMH_LOAD_RESET;
      st.load      <= `TMH_LOAD_RESET;
      st.prescale  <= `TMH_PRESCALE_RESET;
      st.value     <= `TMH_LOAD_RESET;
      st.raw       <= 3'h0;
      st.pwm_level <= 1'b0;
      st.trigger   <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // Outputs
  assign enable_out        = st.enable;
  assign timer_value_out   = st.value;
  assign load_out          = st.load;
  assign prescale_out      = st.prescale;
  assign raw_status_out    = st.raw;
  assign masked_status_out = st.raw & int_mask_in;
  assign irq_out           = |masked_status_out;
  assign adc_trigger_out   = st.trigger;
  assign ccp_pin_out       = st.pwm_level ^ output_invert_in;
  assign ccp_oe_n_out      = (mode != tmh_pkg::TMH_PWM);

  // Checks
  sequence s_oneshot_end;
    (mode == tmh_pkg::TMH_ONESHOT) && timeout && !enable_wr_in &&
      !load_wr_in;
  endsequence

  a_oneshot_stops: assert property (
    @(posedge core_clk_in) disable iff (!reset_n_in)
    s_oneshot_end |=> !enable_out && timer_value_out == load_out)
    else $error("one-shot did not stop and reload");

  a_timeout_flag: assert property (
    @(posedge core_clk_in) disable iff (!reset_n_in)
    timeout |=> raw_status_out[`TMH_FLAG_TIMEOUT])
    else $error("time-out flag not set");

  a_masked_irq: assert property (
    @(posedge core_clk_in) disable iff (!reset_n_in)
    (timeout && int_mask_in[`TMH_FLAG_TIMEOUT]) ##1
      int_mask_in[`TMH_FLAG_TIMEOUT] |-> irq_out)
    else $error("unmasked time-out gave no interrupt");

  a_trigger_gated: assert property (
    @(posedge core_clk_in) disable iff (!reset_n_in)
    adc_trigger_out |-> $past(trigger_enable_in) && $past(timeout))
    else $error("trigger without enable or time-out");

  a_load_taken: assert property (
    @(posedge core_clk_in) disable iff (!reset_n_in)
    load_wr_in && mode != tmh_pkg::TMH_EDGE_TIM
      |=> timer_value_out == $past(load_data_in))
    else $error("load write not taken next clock");

  a_stall_freeze: assert property (
    @(posedge core_clk_in) disable iff (!reset_n_in)
    freeze && !load_wr_in |=> st.count == $past(st.count))
    else $error("count moved while stalled");

  a_match_stop: assert property (
    @(posedge core_clk_in) disable iff (!reset_n_in)
    match_hit && !enable_wr_in && !load_wr_in
      |=> !enable_out && raw_status_out[`TMH_FLAG_MATCH]
          && timer_value_out == load_out)
    else $error("edge count did not stop on match");

  a_capture_hold: assert property (
    @(posedge core_clk_in) disable iff (!reset_n_in)
    (mode == tmh_pkg::TMH_EDGE_TIM) && active && link.edge_event
      |=> timer_value_out == $past(st.count)
          && raw_status_out[`TMH_FLAG_CAPTURE])
    else $error("capture did not latch count");

  a_pwm_quiet: assert property (
    @(posedge core_clk_in) disable iff (!reset_n_in)
    mode == tmh_pkg::TMH_PWM && $past(mode == tmh_pkg::TMH_PWM)
      |-> !$rose(raw_status_out[`TMH_FLAG_TIMEOUT]))
    else $error("status flag raised in PWM mode");

  // PWM wrap from zero and the match point
  sequence s_pwm_wrap;
    (mode == tmh_pkg::TMH_PWM) && active && at_zero && !load_wr_in;
  endsequence

  sequence s_pwm_match;
    (mode == tmh_pkg::TMH_PWM) && active && !at_zero && !load_wr_in &&
      count_dec == match_in && count_dec != st.load;
  endsequence

  a_pwm_set: assert property (
    @(posedge core_clk_in) disable iff (!reset_n_in)
    s_pwm_wrap |=> st.pwm_level && st.count == $past(st.load))
    else $error("PWM level not set at reload");

  a_pwm_clear: assert property (
    @(posedge core_clk_in) disable iff (!reset_n_in)
    s_pwm_match |=> !st.pwm_level)
    else $error("PWM level not cleared at match");

  // Timer reload and idle hold
  a_timer_reload: assert property (
    @(posedge core_clk_in) disable iff (!reset_n_in)
    timeout && !load_wr_in |=> st.count == $past(st.load))
    else $error("timer did not reload after zero");

  a_idle_hold: assert property (
    @(posedge core_clk_in) disable iff (!reset_n_in)
    mode == tmh_pkg::TMH_IDLE && !load_wr_in
      |=> st.count == $past(st.count))
    else $error("count moved outside split mode");

  // Edge modes: match flag, ignored edges, free-running capture counter
  a_match_flag: assert property (
    @(posedge core_clk_in) disable iff (!reset_n_in)
    match_hit |=> raw_status_out[`TMH_FLAG_MATCH])
    else $error("match flag not set");

  a_edge_ignored: assert property (
    @(posedge core_clk_in) disable iff (!reset_n_in)
    mode == tmh_pkg::TMH_EDGE_CNT && !st.enable && !load_wr_in
      |=> st.count == $past(st.count))
    else $error("edge counted while disabled");

  a_edge_time_step: assert property (
    @(posedge core_clk_in) disable iff (!reset_n_in)
    mode == tmh_pkg::TMH_EDGE_TIM && active && !at_zero && !load_wr_in
      |=> st.count == $past(count_dec))
    else $error("edge time counter did not step each clock");

  a_edge_time_wrap: assert property (
    @(posedge core_clk_in) disable iff (!reset_n_in)
    mode == tmh_pkg::TMH_EDGE_TIM && active && at_zero && !load_wr_in
      |=> st.count == $past(st.load))
    else $error("edge time counter did not reload at zero");
endmodule

// *** testbench/tmh_pin_src.sv ***
// Model of the external source that drives the capture pin
module tmh_pin_src (
  // Clock and reset
  input  wire logic       core_clk_in,
  input  wire logic       reset_n_in,
  // Edge request from the bench
  input  wire logic       toggle_in,
  input  wire logic [4:0] hold_in,
  // Pin level and hold status
  output logic            level_out,
  output logic            busy_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] left;

  // Toggle on request, then keep the level for the hold span
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      level_out <= 1'b0;
      left      <= 5'h00;
    end else if (left != 5'h00) begin
      left <= left - 5'h01;
    end else if (toggle_in) begin
      level_out <= ~level_out;
      left      <= (hold_in < 5'h02) ? 5'h02 : hold_in;
    end
  end

  // Busy while the level must not change
  assign busy_out = (left != 5'h00);
endmodule

// *** testbench/tmh_half_tb_top.sv ***
// Self-checking bench for the timer half
module tmh_half_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst_n, cmr, ams, trg, stall, inv, en_wr, en_d;
  logic        ld_wr, ps_wr, halt, req;
  logic [2:0]  cfg, imask, iclr;
  logic [1:0]  mr, esel;
  logic [15:0] match, ld_d;
  logic [7:0]  ps_d;
  logic [4:0]  hold;
  logic        pin, lvl, busy, p_out, oe_n, en_o, irq, adc;
  logic [15:0] tv, ld_o;
  logic [7:0]  ps_o;
  logic [2:0]  raw, msk;
  int          err_count, comparisons, cyc, n, v, seed, p, l;
  int          tq[$], cq[$];
  int          sel[4] = '{0, 1, 3, 2};

  // Pin level: the half wins while its enable is low
  assign pin = oe_n ? lvl : p_out;

  tmh_half dut (
    .core_clk_in(clk), .reset_n_in(rst_n), .global_config_in(cfg),
    .half_mode_in(mr), .capture_mode_in(cmr), .alt_mode_select_in(ams),
    .event_sel_in(esel), .trigger_enable_in(trg), .stall_enable_in(stall),
    .output_invert_in(inv), .match_in(match), .int_mask_in(imask),
    .enable_wr_in(en_wr), .enable_data_in(en_d), .load_wr_in(ld_wr),
    .load_data_in(ld_d), .prescale_wr_in(ps_wr),
    .prescale_data_in(ps_d), .int_clear_in(iclr), .debug_halt_in(halt),
    .ccp_pin_in(pin), .ccp_pin_out(p_out), .ccp_oe_n_out(oe_n),
    .enable_out(en_o), .timer_value_out(tv), .load_out(ld_o),
    .prescale_out(ps_o), .raw_status_out(raw),
    .masked_status_out(msk), .irq_out(irq), .adc_trigger_out(adc));

  tmh_pin_src src (
    .core_clk_in(clk), .reset_n_in(rst_n), .toggle_in(req),
    .hold_in(hold), .level_out(lvl), .busy_out(busy));

  // Clock and cycle counter
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;

  // Compare one value against the model
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Wait a number of sampling points
  task wt(input int k);
    repeat (k) @(negedge clk);
  endtask

  // Software write: 0 enable, 1 load, 2 prescale, 3 flag clear
  task wr(input int k, input int d);
    @(posedge clk);
    en_wr <= (k == 0);
    ld_wr <= (k == 1);
    ps_wr <= (k == 2);
    iclr  <= (k == 3) ? d[2:0] : 3'h0;
    en_d  <= d[0];
    ld_d  <= d[15:0];
    ps_d  <= d[7:0];
    @(posedge clk);
    {en_wr, ld_wr, ps_wr, iclr} <= '0;
    @(negedge clk);
  endtask

  // Ask the pin source for one edge and wait out its hold
  task tgl(input int h);
    @(posedge clk);
    req  <= 1'b1;
    hold <= h[4:0];
    @(posedge clk);
    req <= 1'b0;
    tq.push_back(cyc);
    repeat (40) begin
      @(negedge clk);
      if (!busy) break;
    end
  endtask

  task fin(input string s);
    $display("test %s done", s);
  endtask

  task give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Watchdog against a hung run
  initial begin
    #3000000;
    err_count++;
    give_verdict;
  end

  // Main sequence
  initial begin
    seed = 32'hc84c8ff3;
    cyc = 0;
    {rst_n, cmr, ams, trg, stall, inv, en_wr, en_d} = '0;
    {ld_wr, ps_wr, halt, req} = '0;
    {cfg, mr, esel, imask, iclr, match, ld_d, ps_d} = '0;
    hold = 5'h02;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    wt(1);
    chk(en_o, 0);
    chk(tv, 16'hffff);
    chk(ld_o, 16'hffff);
    chk(ps_o, 8'h00);
    chk(raw, 3'h0);
    fin("reset");
    // Counting only in split mode
    @(posedge clk);
    mr <= 2'h2;
    wr(0, 1);
    wt(5);
    chk(tv, 16'hffff);
    @(posedge clk);
    cfg <= 3'h4;
    wt(3);
    chk(tv !== 16'hffff, 1);
    wr(0, 0);
    fin("split");
    // One-shot from load 2
    @(posedge clk);
    mr <= 2'h1;
    imask <= 3'h1;
    wr(1, 2);
    wr(3, 7);
    wr(0, 1);
    n = 0;
    while (en_o === 1'b1 && n < 50) begin
      n++;
      wt(1);
    end
    chk(n, 3);
    chk(tv, 16'h0002);
    chk(raw[0], 1);
    chk({irq, msk}, 4'h9);
    chk(adc, 0);
    wt(4);
    chk(raw[0], 1);
    @(posedge clk);
    imask <= 3'h0;
    wt(1);
    chk({irq, msk}, 4'h0);
    wr(3, 1);
    chk(raw, 3'h0);
    fin("one-shot");
    // Periodic with a random and the largest prescale
    for (int i = 0; i < 2; i++) begin
      p = i ? 255 : ($random(seed) & 3);
      l = 2 + ($random(seed) & 3);
      @(posedge clk);
      mr <= 2'h2;
      trg <= 1'b1;
      wr(2, p);
      chk(ps_o, p);
      wr(1, l);
      wr(0, 1);
      tq.delete();
      cq.delete();
      v = tv;
      repeat (3 * (l + 1) * (p + 1) + 4) begin
        wt(1);
        if (adc === 1'b1) tq.push_back(cyc);
        if (tv !== v) cq.push_back(cyc);
        v = tv;
      end
      chk(tq[1] - tq[0], (l + 1) * (p + 1));
      chk(cq[2] - cq[1], p + 1);
      @(posedge clk);
      trg <= 1'b0;
      n = 0;
      repeat ((l + 1) * (p + 1) + 2) begin
        wt(1);
        n += adc;
      end
      chk(n, 0);
      wr(0, 0);
    end
    fin("periodic");
    // Load written while running, then debug stall
    wr(2, 0);
    wr(1, 16'h0100);
    wr(0, 1);
    wt(3);
    wr(1, 16'h0030);
    chk({tv, ld_o}, 32'h00300030);
    wt(1);
    chk(tv, 16'h002f);
    @(posedge clk);
    stall <= 1'b1;
    halt <= 1'b1;
    wt(2);
    v = tv;
    wt(8);
    chk(tv, v);
    @(posedge clk);
    halt <= 1'b0;
    wt(3);
    chk(tv !== v, 1);
    @(posedge clk);
    stall <= 1'b0;
    halt <= 1'b1;
    wt(2);
    v = tv;
    wt(2);
    chk(tv !== v, 1);
    @(posedge clk);
    halt <= 1'b0;
    wr(0, 0);
    fin("reload and stall");
    // Edge count for every edge selection
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      mr <= 2'h3;
      esel <= sel[i][1:0];
      match <= 16'h0006;
      imask <= 3'h2;
      wr(1, 8);
      wr(3, 7);
      wr(0, 1);
      tgl(2 + ($random(seed) & 3));
      wt(6);
      chk(tv, (sel[i] == 0 || sel[i] == 3) ? 7 : 8);
      repeat (3) tgl(2 + ($random(seed) & 3));
      wt(6);
      chk({raw[1], msk[1]}, (sel[i] != 2) ? 3 : 0);
      chk({en_o, tv}, {sel[i] == 2, 16'h0008});
      wr(0, 0);
    end
    fin("edge count");
    // Edge time captures with a short reload period
    @(posedge clk);
    cmr <= 1'b1;
    esel <= 2'h3;
    imask <= 3'h4;
    wr(2, 3);
    wr(1, 16'h0010);
    wr(3, 7);
    wr(0, 1);
    tq.delete();
    cq.delete();
    repeat (4) begin
      tgl(9 + ($random(seed) & 7));
      wt(2);
      cq.push_back(tv);
    end
    chk({irq, msk[2], raw[2]}, 3'h7);
    for (int i = 1; i < 4; i++)
      chk(((cq[i-1] - cq[i] - (tq[i] - tq[i-1])) % 17 + 17) % 17, 0);
    wr(0, 0);
    wr(3, 7);
    wr(2, 0);
    fin("edge time");
    // PWM duty, plain and inverted
    @(posedge clk);
    cmr <= 1'b0;
    ams <= 1'b1;
    mr <= 2'h2;
    match <= 16'h0003;
    wr(1, 9);
    wr(0, 1);
    for (int k = 0; k < 2; k++) begin
      wt(12);
      n = 0;
      repeat (10) begin
        wt(1);
        n += pin;
      end
      chk(n, k ? 4 : 6);
      chk({oe_n, raw}, 4'h0);
      @(posedge clk);
      inv <= 1'b1;
    end
    wr(0, 0);
    @(posedge clk);
    ams <= 1'b0;
    wt(1);
    chk(oe_n, 1);
    fin("pwm");
    give_verdict;
  end
endmodule
